// ==== verilog/aww_map.svh ====
/*
 * Register offsets, field positions, reset values and limits of the analog
 * window watchdog. Assumes an 8-bit APB byte address and 32-bit data.
 */
`ifndef AWW_MAP_SVH
`define AWW_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define AWW_OFS_CTRL       8'h00
`define AWW_OFS_GAIN       8'h04
`define AWW_OFS_OFFSET     8'h08
`define AWW_OFS_UPPER      8'h0c
`define AWW_OFS_LOWER      8'h10
`define AWW_OFS_SRC_SEL    8'h14
`define AWW_OFS_STATUS     8'h18
`define AWW_OFS_REF        8'h1c
`define AWW_OFS_LIVE       8'h20
`define AWW_OFS_EFF_UPPER  8'h24
`define AWW_OFS_EFF_LOWER  8'h28

// ****************************************
// field positions
// ****************************************
`define AWW_CTRL_RETAIN     0
`define AWW_CTRL_UPPER_EXT  1
`define AWW_CTRL_LOWER_EXT  2
`define AWW_CTRL_DEC_LSB    4
`define AWW_SRC_UPPER_LSB   0
`define AWW_SRC_LOWER_LSB   8
`define AWW_STAT_ALARM      0
`define AWW_STAT_ARMED      1
`define AWW_STAT_REF_VALID  2

// ****************************************
// reset values and limits
// ****************************************
`define AWW_GAIN_RESET     11'sd100
`define AWW_GAIN_MAX       1000
`define AWW_OFFSET_MAX     10000
`define AWW_MARGIN_MAX     20000
`define AWW_GAIN_DIVISOR   22'sd100
`define AWW_DEC_MAX        3

`endif

// ==== verilog/aww_pkg.sv ====
/*
 * Types shared by the analog window watchdog files.
 * Assumes aww_map.svh supplies the numeric constants.
 */
`default_nettype none

package aww_pkg;

	// scaled value, wide enough for reference plus or minus a margin
	typedef logic signed [17:0] aww_val_t;

	// raw analog sample, 0 to 1000
	typedef logic [9:0] aww_sample_t;

	// configuration written by software
	typedef struct packed {
		logic signed [10:0] gain;
		logic signed [14:0] offset;
		logic [14:0]        upper_margin;
		logic [14:0]        lower_margin;
		logic [7:0]         upper_blk;
		logic [7:0]         lower_blk;
		logic               upper_ext;
		logic               lower_ext;
		logic               retain;
		logic [1:0]         decimals;
	} aww_cfg_s;

	// live status of the monitor
	typedef struct packed {
		logic ref_valid;
		logic armed;
		logic alarm;
	} aww_stat_s;

endpackage : aww_pkg

`default_nettype wire

// ==== verilog/aww_scale.sv ====
/*
 * Scaler: registered sample * gain / 100 + offset.
 * Assumes gain in hundredths within +-1000 and offset within +-10000.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aww_map.svh"

module aww_scale (
	// clock and reset
	input  wire logic                pclk,
	input  wire logic                presetn,
	// operands
	input  wire aww_pkg::aww_sample_t sample,
	input  wire logic signed [10:0]  gain,
	input  wire logic signed [14:0]  offset,
	// result
	output var  aww_pkg::aww_val_t   scaled
);

	logic signed [21:0] prod;
	logic signed [21:0] quo;
	logic signed [21:0] sum;

	// division truncates toward zero, same as the integer arithmetic of the function
	always_comb begin
		prod = $signed({1'b0, sample}) * gain;
		quo  = prod / `AWW_GAIN_DIVISOR;
		sum  = quo + {{7{offset[14]}}, offset};
	end

	// one register stage keeps the divider off the compare path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scaled <= '0;
		end else begin
			scaled <= sum[17:0];
		end
	end

endmodule : aww_scale

`default_nettype wire

// ==== verilog/aww_top.sv ====
/*
 * Analog window watchdog with an APB3 register slave.
 * Assumes analog_sample_in and block_values come from logic on pclk,
 * arm_in comes from a pin, restart_pulse from the system controller on pclk.
 */
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "aww_map.svh"

module aww_top #(
	parameter int N_BLK = 8
) (
	// clock and reset
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output      logic [31:0]           prdata,
	output      logic                  pready,
	output      logic                  pslverr,
	// monitored signal and arming pin
	input  wire aww_pkg::aww_sample_t  analog_sample_in,
	input  wire logic                  arm_in,
	// live values of other blocks, 16-bit signed each
	input  wire logic [N_BLK*16-1:0]   block_values,
	// power return after a power loss
	input  wire logic                  restart_pulse,
	// alarm to the consumer
	output      logic                  alarm
);

	// ****************************************
	// declarations
	// ****************************************
	aww_pkg::aww_cfg_s  cfg;
	aww_pkg::aww_stat_s stat;
	aww_pkg::aww_val_t  live_scaled;
	aww_pkg::aww_val_t  ref_value;
	aww_pkg::aww_val_t  eff_upper;
	aww_pkg::aww_val_t  eff_lower;
	aww_pkg::aww_val_t  win_high;
	aww_pkg::aww_val_t  win_low;
	logic               arm_s1;
	logic               arm_s2;
	logic               arm_q;
	logic               arm_rise;
	logic               outside;
	logic               wr_en;
	logic               rd_setup;
	logic               ref_valid;

	// ****************************************
	// helper functions
	// ****************************************

	// every printed offset of the map
	// shared by pslverr and the write enable, so both agree on the map
	function automatic logic is_mapped(input logic [7:0] a);
		if (a == `AWW_OFS_CTRL)
			return 1'b1;
		else if (a == `AWW_OFS_GAIN)
			return 1'b1;
		else if (a == `AWW_OFS_OFFSET)
			return 1'b1;
		else if (a == `AWW_OFS_UPPER)
			return 1'b1;
		else if (a == `AWW_OFS_LOWER)
			return 1'b1;
		else if (a == `AWW_OFS_SRC_SEL)
			return 1'b1;
		else if (a == `AWW_OFS_STATUS)
			return 1'b1;
		else if (a == `AWW_OFS_REF)
			return 1'b1;
		else if (a == `AWW_OFS_LIVE)
			return 1'b1;
		else if (a == `AWW_OFS_EFF_UPPER)
			return 1'b1;
		else if (a == `AWW_OFS_EFF_LOWER)
			return 1'b1;
		else
			return 1'b0;
	endfunction : is_mapped

	// saturate a signed word into lo..hi
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		if (v < lo)
			return lo;
		else if (v > hi)
			return hi;
		else
			return v;
	endfunction : clamp

	// pick a block's live value, unknown block numbers read as zero
	// negative values clamp to zero: a margin never narrows below the reference
	function automatic aww_pkg::aww_val_t pick_block(input logic [N_BLK*16-1:0] vals,
		input logic [7:0] idx);
		logic signed [31:0] v;
		v = 32'sd0;
		for (int i = 0; i < N_BLK; i++) begin
			if (idx == i[7:0]) begin
				v = 32'($signed(vals[i*16 +: 16]));
			end
		end
		v = clamp(v, 32'sd0, 32'sd`AWW_MARGIN_MAX);
		return v[17:0];
	endfunction : pick_block

	// ****************************************
	// apb slave
	// ****************************************

	// zero wait states: every access completes in its first access cycle
	// read-only words ignore writes without an error; only unmapped offsets set pslverr
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~is_mapped(paddr);
	assign wr_en    = psel & penable & pwrite & is_mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;

	// configuration writes, out-of-range values saturate
	// saturating here keeps the scaler and the compare inside their word widths
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg              <= '0;
			cfg.gain         <= `AWW_GAIN_RESET;
		end else if (wr_en) begin
			if (paddr == `AWW_OFS_CTRL) begin
				cfg.retain    <= pwdata[`AWW_CTRL_RETAIN];
				cfg.upper_ext <= pwdata[`AWW_CTRL_UPPER_EXT];
				cfg.lower_ext <= pwdata[`AWW_CTRL_LOWER_EXT];
				cfg.decimals  <= pwdata[`AWW_CTRL_DEC_LSB +: 2];
			end else if (paddr == `AWW_OFS_GAIN) begin
				cfg.gain <= 11'(clamp($signed(pwdata), -32'sd`AWW_GAIN_MAX,
					32'sd`AWW_GAIN_MAX));
			end else if (paddr == `AWW_OFS_OFFSET) begin
				cfg.offset <= 15'(clamp($signed(pwdata), -32'sd`AWW_OFFSET_MAX,
					32'sd`AWW_OFFSET_MAX));
			end else if (paddr == `AWW_OFS_UPPER) begin
				cfg.upper_margin <= 15'(clamp($signed(pwdata), 32'sd0,
					32'sd`AWW_MARGIN_MAX));
			end else if (paddr == `AWW_OFS_LOWER) begin
				cfg.lower_margin <= 15'(clamp($signed(pwdata), 32'sd0,
					32'sd`AWW_MARGIN_MAX));
			end else if (paddr == `AWW_OFS_SRC_SEL) begin
				cfg.upper_blk <= pwdata[`AWW_SRC_UPPER_LSB +: 8];
				cfg.lower_blk <= pwdata[`AWW_SRC_LOWER_LSB +: 8];
			end
		end
	end

	// read data loaded in the setup cycle, so it stands through the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_setup) begin
			if (paddr == `AWW_OFS_CTRL)
				prdata <= {26'h0, cfg.decimals, 1'b0, cfg.lower_ext, cfg.upper_ext, cfg.retain};
			else if (paddr == `AWW_OFS_GAIN)
				prdata <= 32'($signed(cfg.gain));
			else if (paddr == `AWW_OFS_OFFSET)
				prdata <= 32'($signed(cfg.offset));
			else if (paddr == `AWW_OFS_UPPER)
				prdata <= {17'h0, cfg.upper_margin};
			else if (paddr == `AWW_OFS_LOWER)
				prdata <= {17'h0, cfg.lower_margin};
			else if (paddr == `AWW_OFS_SRC_SEL)
				prdata <= {16'h0, cfg.lower_blk, cfg.upper_blk};
			else if (paddr == `AWW_OFS_STATUS)
				prdata <= {29'h0, stat};
			else if (paddr == `AWW_OFS_REF)
				prdata <= 32'(ref_value);
			else if (paddr == `AWW_OFS_LIVE)
				prdata <= 32'(live_scaled);
			else if (paddr == `AWW_OFS_EFF_UPPER)
				prdata <= 32'(eff_upper);
			else if (paddr == `AWW_OFS_EFF_LOWER)
				prdata <= 32'(eff_lower);
			else
				prdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// arming input
	// ****************************************

	// two-stage synchroniser, edge detect looks only at the second stage
	// arm_q only delays the second stage; the first may still be settling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_s1 <= 1'b0;
			arm_s2 <= 1'b0;
			arm_q  <= 1'b0;
		end else begin
			arm_s1 <= arm_in;
			arm_s2 <= arm_s1;
			arm_q  <= arm_s2;
		end
	end

	assign arm_rise = arm_s2 & ~arm_q;

	// ****************************************
	// scaling and reference capture
	// ****************************************

	// one shared scaler: the reference is the scaled live value at capture time
	// the trade: the reference is one clock older than the synchronised arm edge
	aww_scale u_scale (
		.pclk    (pclk),
		.presetn (presetn),
		.sample  (analog_sample_in),
		.gain    (cfg.gain),
		.offset  (cfg.offset),
		.scaled  (live_scaled)
	);

	// reference survives a restart only when retention is on
	// capture wins over a same-cycle restart, so a fresh reference is never lost
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_value <= '0;
			ref_valid <= 1'b0;
		end else if (arm_rise) begin
			ref_value <= live_scaled;
			ref_valid <= 1'b1;
		end else if (restart_pulse && !cfg.retain) begin
			ref_value <= '0;
			ref_valid <= 1'b0;
		end
	end

	// ****************************************
	// window compare
	// ****************************************

	// margins from fixed constants or another block's live value
	// an external margin is read live every cycle, not latched
	always_comb begin
		eff_upper = cfg.upper_ext ? pick_block(block_values, cfg.upper_blk)
			: {3'b000, cfg.upper_margin};
		eff_lower = cfg.lower_ext ? pick_block(block_values, cfg.lower_blk)
			: {3'b000, cfg.lower_margin};
	end

	// decimals never enter here; bounds are inclusive
	// 18-bit signed words hold reference plus or minus 20000 without overflow
	always_comb begin
		win_high = ref_value + eff_upper;
		win_low  = ref_value - eff_lower;
		outside  = (live_scaled > win_high) || (live_scaled < win_low);
	end

	// alarm follows the synchronised arm level one clock later
	// without a valid reference there is no window, so a cleared reference never alarms
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm <= 1'b0;
		end else if (!arm_s2) begin
			alarm <= 1'b0;
		end else if (restart_pulse && !cfg.retain) begin
			alarm <= 1'b0;
		end else if (arm_rise) begin
			alarm <= 1'b0; // new reference, the sample is inside by definition
		end else if (!ref_valid) begin
			alarm <= 1'b0;
		end else begin
			alarm <= outside;
		end
	end

	// ****************************************
	// status
	// ****************************************

	// status word for software
	always_comb begin
		stat.alarm     = alarm;
		stat.armed     = arm_s2;
		stat.ref_valid = ref_valid;
	end

endmodule : aww_top

`default_nettype wire

// ==== verification/aww_monitor.sv ====
/* checker on the ports of aww_top
   assumes APB3 zero wait states, map ends at 0x28 */
`timescale 1ns/1ps
`default_nettype none
module aww_monitor #(
	parameter int N_BLK = 8
) (
	// clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// apb
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	// monitor side
	input wire aww_pkg::aww_sample_t analog_sample_in,
	input wire logic               arm_in,
	input wire logic [N_BLK*16-1:0] block_values,
	input wire logic               restart_pulse,
	input wire logic               alarm
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic keep;
	assign acc = psel && penable;
	// copy of the retain bit, seen from bus writes only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) keep <= 1'b0;
		else if (acc && pwrite && paddr == 8'h00) keep <= pwdata[0];
	end
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; acc && paddr > 8'h28 |-> pslverr; endproperty
	a_err: assert property (p_err) else $error("no error on unmapped");
	property p_ok; acc && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
	a_ok: assert property (p_ok) else $error("error on mapped");
	property p_rd0; acc && !pwrite && pslverr |-> prdata == 32'h0; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_armlow; !arm_in [*4] |-> !alarm; endproperty
	a_armlow: assert property (p_armlow) else $error("alarm while disarmed");
	// the rise cycle itself never alarms, so arm is high four edges back
	property p_armed; alarm |-> $past(arm_in, 3) && $past(arm_in, 4); endproperty
	a_armed: assert property (p_armed) else $error("alarm without arming");
	property p_rst; $rose(presetn) |-> !alarm; endproperty
	a_rst: assert property (p_rst) else $error("alarm after reset");
	property p_restart; restart_pulse && !keep |=> !alarm; endproperty
	a_restart: assert property (p_restart) else $error("alarm kept on restart");
	cover property (alarm);
	cover property (restart_pulse && keep);
	cover property (acc && pslverr);
endmodule : aww_monitor
bind aww_top aww_monitor #(.N_BLK(N_BLK)) aww_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .analog_sample_in(analog_sample_in), .arm_in(arm_in), .block_values(block_values),
	.restart_pulse(restart_pulse), .alarm(alarm));
`default_nettype wire

// ==== verification/aww_src.sv ====
/* analog sample source model
   assumes requests change after pclk edges */
`timescale 1ns/1ps
`default_nettype none
module aww_src (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// requested level and sample out
	input  wire logic [9:0]           want,
	output var  aww_pkg::aww_sample_t sample
);
	// converter output, full scale 1000, one cycle late
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) sample <= 10'h000;
		else sample <= (want > 10'd1000) ? 10'd1000 : want;
	end
endmodule : aww_src
`default_nettype wire

// ==== verification/tb.sv ====
/* testbench for aww_top
   assumes aww_monitor bound and aww_src as source */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm, arm_in, restart_pulse, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [127:0] blk;
	logic [9:0]  want;
	aww_pkg::aww_sample_t smp;
	int n_fail, compares, cyc, i;
	logic [9:0] tv [4] = '{10'd550, 10'd551, 10'd470, 10'd469};
	logic       ta [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	aww_top #(.N_BLK(8)) aww_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analog_sample_in(smp), .arm_in(arm_in), .block_values(blk), .restart_pulse(restart_pulse),
		.alarm(alarm));
	aww_src aww_src_i (.pclk(pclk), .presetn(presetn), .want(want), .sample(smp));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task complete_run;
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : complete_run
	// hang guard, far beyond the roughly 150 cycles needed
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run;
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	// one apb transfer, held until pready is seen
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rdc
	// alarm settles two edges after the sample
	task smp_chk(input logic [9:0] v, input logic e);
		want <= v;
		repeat (5) @(posedge pclk);
		chk({31'h0, alarm}, {31'h0, e});
	endtask : smp_chk
	task rearm;
		arm_in <= 1'b0;
		repeat (4) @(posedge pclk);
		arm_in <= 1'b1;
		repeat (6) @(posedge pclk);
	endtask : rearm
	task restart;
		restart_pulse <= 1'b1;
		@(posedge pclk);
		restart_pulse <= 1'b0;
		@(posedge pclk);
	endtask : restart
	initial begin
		{presetn, psel, penable, pwrite, arm_in, restart_pulse} = 6'h00;
		{paddr, pwdata, blk, want} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdc(8'h04, 32'h64);
		rdc(8'h1c, 32'h0);
		rdc(8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		xfer(1'b1, 8'h04, 32'd2000);
		rdc(8'h04, 32'd1000);
		xfer(1'b1, 8'h04, 32'hffffec78);
		rdc(8'h04, 32'hfffffc18);
		xfer(1'b1, 8'h08, 32'd20000);
		rdc(8'h08, 32'd10000);
		xfer(1'b1, 8'h0c, 32'd30000);
		rdc(8'h0c, 32'd20000);
		xfer(1'b1, 8'h04, 32'd250);
		xfer(1'b1, 8'h08, 32'hfffffed4);
		xfer(1'b1, 8'h00, 32'h30);
		want <= 10'd333;
		repeat (4) @(posedge pclk);
		rdc(8'h20, 32'd532);
		xfer(1'b1, 8'h04, 32'h64);
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h0c, 32'd50);
		xfer(1'b1, 8'h10, 32'd30);
		want <= 10'd500;
		rearm;
		rdc(8'h1c, 32'd500);
		for (i = 0; i < 4; i++) smp_chk(tv[i], ta[i]);
		arm_in <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({31'h0, alarm}, 32'h0);
		rearm;
		chk({31'h0, alarm}, 32'h0);
		blk[47:32] <= 16'd10;
		xfer(1'b1, 8'h14, 32'h2);
		xfer(1'b1, 8'h00, 32'h2);
		rdc(8'h24, 32'd10);
		smp_chk(10'd479, 1'b0);
		smp_chk(10'd480, 1'b1);
		restart;
		chk({31'h0, alarm}, 32'h0);
		rdc(8'h1c, 32'h0);
		chk({31'h0, alarm}, 32'h0);
		xfer(1'b1, 8'h00, 32'h3);
		rearm;
		restart;
		rdc(8'h1c, 32'd480);
		complete_run;
	end
endmodule : tb
`default_nettype wire
